//--- dv/channel_limit_monitor_checker.sv
// Concurrent checks on the channel limit monitor ports.
`timescale 1ns/1ns
module channel_limit_monitor_checker (
   input wire clock,
   input wire sys_rst,
   input wire soft_reset,
   input wire conv_valid,
   input wire [3:0] conv_chan,
   input wire int_drive_always,
   input wire int_active_high,
   input wire [3:0] host_chan,
   input wire cfg_wr,
   input wire clr_all,
   input wire clr_chan,
   input wire [23:0] alarm_status,
   input wire int_out,
   input wire int_oe,
   input wire busy
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst || soft_reset);
   reg live_r;
   wire any_alarm = |alarm_status;
   wire [19:0] pairs = alarm_status[23:4];
   wire both_set = |(pairs & (pairs >> 1) & 20'h55555);
   always @(posedge clock) live_r <= !(sys_rst || soft_reset);
   sequence conv_taken; conv_valid && !busy && conv_chan < 4'h2; endsequence
   sequence filt_done; busy ##[1:3] !busy; endsequence
   busy_span_a: assert property (conv_taken |=> filt_done)
      else $error("busy did not span the conversion");
   oe_level_a: assert property (live_r |->
      int_oe == ($past(int_drive_always) | any_alarm))
      else $error("interrupt enable wrong");
   out_level_a: assert property (live_r |->
      int_out == (any_alarm ~^ $past(int_active_high)))
      else $error("interrupt level wrong");
   code_legal_a: assert property (!both_set)
      else $error("alarm pair holds code 11");
   reserved_zero_a: assert property (alarm_status[3:0] == 4'h0)
      else $error("reserved alarm bits set");
   rise_cause_a: assert property (
      (alarm_status & ~$past(alarm_status)) != 24'h0 |-> $past(conv_valid, 4))
      else $error("alarm rose without a conversion");
   clear_all_a: assert property (clr_all && !$past(conv_valid, 2)
      |-> ##2 alarm_status == 24'h0) else $error("clear all failed");
   clear_one_a: assert property ((clr_chan || cfg_wr) && host_chan < 4'ha &&
      !$past(conv_valid, 2) |-> ##2 ((alarm_status >>
      (5'd22 - {$past(host_chan, 2), 1'b0})) & 24'h3) == 24'h0)
      else $error("channel clear failed");
endmodule // channel_limit_monitor_checker
bind channel_limit_monitor channel_limit_monitor_checker
   channel_limit_monitor_checker_i (.clock, .sys_rst, .soft_reset,
   .conv_valid, .conv_chan, .int_drive_always, .int_active_high, .host_chan,
   .cfg_wr, .clr_all, .clr_chan, .alarm_status, .int_out, .int_oe, .busy);

//--- dv/channel_limit_monitor_tb.sv
// Self-checking bench for the channel limit monitor.
`timescale 1ns/1ns
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin \
   err_total++; $display("wrong value %s exp %h got %h", n, e, a); end end
module channel_limit_monitor_tb;
   logic clock = 0, sys_rst = 1, soft_reset = 0, conv_valid = 0, cfg_wr = 0;
   logic data_wr = 0, clr_all = 0, clr_chan = 0;
   logic int_drive_always = 0, int_active_high = 0;
   logic [3:0] conv_chan = 0, host_chan = 0, diff_pair = 0;
   logic [11:0] conv_value = 0, cfg_wr_upper = 0, cfg_wr_lower = 0;
   logic [11:0] data_wr_value = 0;
   logic [9:0] chan_signed = 0;
   logic [7:0] cfg_wr_byte = 0;
   wire [11:0] rd_result, rd_upper, rd_lower;
   wire [7:0] rd_cfg;
   wire [23:0] alarm_status;
   wire int_out, int_oe, busy, int_line;
   int err_total = 0, checks_done = 0;
   channel_limit_monitor channel_limit_monitor_i (.*);
   int_line_host int_line_host_i (.int_out, .int_oe, .int_line);
   initial forever #5 clock = ~clock;
   task stop_test;
      $display("Checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(negedge clock);
   endtask
   task conv(input [3:0] c, input [11:0] v);
      int i;
      for (i = 0; i < 8 && busy !== 1'b0; i++) cyc(1);
      if (busy !== 1'b0) begin
         err_total++;
         stop_test;
      end
      conv_chan = c;
      conv_value = v;
      conv_valid = 1;
      cyc(1);
      conv_valid = 0;
      cyc(4);
   endtask
   task cfg(input [3:0] c, input [11:0] u, l, input [7:0] b);
      host_chan = c;
      {cfg_wr_upper, cfg_wr_lower, cfg_wr_byte} = {u, l, b};
      cfg_wr = 1;
      cyc(1);
      cfg_wr = 0;
      cyc(1);
   endtask
   task clear(input all, input [3:0] c);
      host_chan = c;
      clr_all = all;
      clr_chan = !all;
      cyc(1);
      {clr_all, clr_chan} = 2'b00;
      cyc(1);
   endtask
   task chk_rd(input [3:0] c, input [11:0] r, u, l, input [7:0] b);
      host_chan = c;
      cyc(1);
      `CHK("result", r, rd_result)
      `CHK("upper", u, rd_upper)
      `CHK("lower", l, rd_lower)
      `CHK("config", b, rd_cfg)
   endtask
   task chk_al(input [23:0] a, input o, e);
      `CHK("alarm", a, alarm_status)
      `CHK("int_out", o, int_out)
      `CHK("int_oe", e, int_oe)
      `CHK("int_line", e ? o : 1'b1, int_line)
   endtask
   task t_reset;
      chk_rd(0, 12'h800, 12'hfff, 12'h000, 8'h00);
      chk_rd(9, 12'h800, 12'hfff, 12'h000, 8'h00);
      chk_al(24'h0, 1, 0);
   endtask
   task t_count;
      cfg(2, 12'h100, 12'h050, 8'h20);
      chk_rd(2, 12'h800, 12'h100, 12'h050, 8'h20);
      repeat (3) conv(2, 12'h100);
      conv(2, 12'h101);
      conv(2, 12'h101);
      conv(2, 12'h040);
      conv(2, 12'h040);
      chk_al(24'h0, 1, 0);
      conv(2, 12'h040);
      chk_al(24'h040000, 0, 1);
      clear(0, 2);
      chk_al(24'h0, 1, 0);
   endtask
   task t_signed;
      chan_signed = 10'h001;
      {int_drive_always, int_active_high} = 2'b11;
      cfg(0, 12'h010, 12'hff0, 8'h00);
      conv(0, 12'hfe0);
      chk_al(24'h400000, 1, 1);
      clear(1, 0);
      chk_al(24'h0, 0, 1);
      conv(0, 12'h020);
      chk_al(24'h800000, 1, 1);
      cfg(0, 12'h010, 12'hff0, 8'h00);
      chk_al(24'h0, 0, 1);
   endtask
   task t_avg;
      cfg(3, 12'hfff, 12'h000, 8'h01);
      data_wr_value = 12'h100;
      data_wr = 1;
      cyc(1);
      data_wr = 0;
      chk_rd(3, 12'h100, 12'hfff, 12'h000, 8'h01);
      conv(3, 12'h300);
      chk_rd(3, 12'h200, 12'hfff, 12'h000, 8'h01);
      conv(3, 12'h300);
      chk_rd(3, 12'h280, 12'hfff, 12'h000, 8'h01);
      cfg(3, 12'hfff, 12'h000, 8'h0c);
      conv(3, 12'h123);
      chk_rd(3, 12'h123, 12'hfff, 12'h000, 8'h0c);
      diff_pair = 4'h1;
      conv(3, 12'h7ff);
      chk_rd(3, 12'h123, 12'hfff, 12'h000, 8'h0c);
      soft_reset = 1;
      cyc(1);
      soft_reset = 0;
      chk_rd(3, 12'h800, 12'hfff, 12'h000, 8'h00);
   endtask
   initial begin
      cyc(3);
      sys_rst = 0;
      t_reset;
      t_count;
      t_signed;
      t_avg;
      stop_test;
   end
   initial begin
      #200000;
      err_total++;
      stop_test;
   end
endmodule // channel_limit_monitor_tb

//--- dv/int_line_host.sv
// Host side of the interrupt line: a pull-up resolves the shared wire.
`timescale 1ns/1ns
module int_line_host (
   input wire int_out,
   input wire int_oe,
   output wire int_line
);
   // Released line floats to the pull-up level.
   assign int_line = int_oe ? int_out : 1'b1;
endmodule // int_line_host

//--- hdl/channel_average_filter.v
// Recursive averaging step with 24 bits of internal precision.
`timescale 1ns/1ns
`include "channel_limit_monitor_defines.vh"
module channel_average_filter (
   input wire [23:0] acc,
   input wire [11:0] sample,
   input wire [3:0] avg_code,
   input wire is_signed,
   output wire [23:0] acc_nxt
);
   // Reserved codes fall back to no averaging.
   wire [3:0] shift_amt;
   wire [24:0] acc_ext;
   wire [24:0] smp_ext;
   wire signed [24:0] acc_div;
   wire signed [24:0] smp_div;
   wire [24:0] sum;
   assign shift_amt = (avg_code > `CLM_AVG_CODE_MAX) ? 4'h0
      : avg_code;
   assign acc_ext = {is_signed & acc[23], acc};
   assign smp_ext = {is_signed & sample[11], sample, `CLM_FRAC_ZERO};
   assign acc_div = $signed(acc_ext) >>> shift_amt;
   assign smp_div = $signed(smp_ext) >>> shift_amt;
   // Stored value times (N-1)/N plus the new sample over N.
   assign sum = acc_ext - acc_div + smp_div;
   assign acc_nxt = sum[23:0];
endmodule // channel_average_filter

//--- hdl/channel_limit_monitor.v
// Per-channel averaging, limit checking, fault counting and alarm output.
`timescale 1ns/1ns
`include "channel_limit_monitor_defines.vh"
module channel_limit_monitor (
   input wire clock,
   input wire sys_rst,
   input wire soft_reset,
   input wire conv_valid,
   input wire [3:0] conv_chan,
   input wire [11:0] conv_value,
   input wire [9:0] chan_signed,
   input wire [3:0] diff_pair,
   input wire int_drive_always,
   input wire int_active_high,
   input wire [3:0] host_chan,
   input wire cfg_wr,
   input wire [11:0] cfg_wr_upper,
   input wire [11:0] cfg_wr_lower,
   input wire [7:0] cfg_wr_byte,
   input wire data_wr,
   input wire [11:0] data_wr_value,
   input wire clr_all,
   input wire clr_chan,
   output reg [11:0] rd_result,
   output reg [11:0] rd_upper,
   output reg [11:0] rd_lower,
   output reg [7:0] rd_cfg,
   output reg [23:0] alarm_status,
   output reg int_out,
   output reg int_oe,
   output wire busy
);
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_FILT = 3'b010;
   localparam [2:0] ST_EVAL = 3'b100;

   reg [23:0] acc_r [0:9];
   reg [11:0] upper_r [0:9];
   reg [11:0] lower_r [0:9];
   reg [7:0] cfg_r [0:9];
   reg [4:0] cnt_r [0:9];
   reg [1:0] side_r [0:9];
   reg [23:0] alarm_r;
   reg [2:0] state_r;
   reg [3:0] ch_r;
   reg [11:0] sample_r;
   integer i;

   wire rst_all;
   wire host_ok;
   wire conv_take;
   wire [23:0] filt_nxt;
   wire [11:0] eval_data;
   wire eval_sgn;
   wire above;
   wire below;
   wire [1:0] eval_side;
   wire [4:0] cnt_nxt;
   wire [3:0] fault_limit;
   wire alarm_any;
   wire level_active;
   wire filt_step;
   wire eval_step;
   wire host_cfg;
   wire host_data;
   wire host_clr;
   wire alarm_hit;
   wire [4:0] clr_lsb;
   wire [4:0] set_lsb;
   wire int_out_nxt;
   wire int_oe_nxt;
   reg [2:0] state_nxt;
   reg [3:0] ch_nxt;
   reg [11:0] sample_nxt;
   reg [23:0] alarm_nxt;
   reg [11:0] rd_result_nxt;
   reg [11:0] rd_upper_nxt;
   reg [11:0] rd_lower_nxt;
   reg [7:0] rd_cfg_nxt;

   // True when a channel is the odd half of a differential pair.
   function odd_of_pair;
      input [3:0] ch;
      input [3:0] pairs;
      reg [3:0] idx;
      begin
         idx = ch - `CLM_CHAN_AIN_FIRST;
         odd_of_pair = 1'b0;
         if (ch >= `CLM_CHAN_AIN_FIRST && ch[0]) begin
            odd_of_pair = pairs[idx[2:1]];
         end
      end
   endfunction

   // Compares two values as unsigned or two's complement.
   function greater;
      input [11:0] a;
      input [11:0] b;
      input sgn;
      begin
         if (sgn) begin
            greater = $signed(a) > $signed(b);
         end else begin
            greater = a > b;
         end
      end
   endfunction

   // Lowest bit of a channel's pair in the alarm word.
   function [4:0] alarm_lsb;
      input [3:0] ch;
      reg [4:0] twice;
      begin
         twice = {ch, 1'b0};
         alarm_lsb = 5'h16 - twice;
      end
   endfunction

   // Adds one to a fault count, holding at the top of the range.
   function [4:0] count_up;
      input [4:0] cnt;
      begin
         if (cnt == `CLM_CNT_MAX) begin
            count_up = `CLM_CNT_MAX;
         end else begin
            count_up = cnt + 5'h01;
         end
      end
   endfunction

   assign rst_all = sys_rst | soft_reset;
   assign host_ok = host_chan < `CLM_NUM_CHAN;
   assign busy = ~state_r[0];
   assign conv_take = conv_valid && conv_chan < `CLM_NUM_CHAN
      && !odd_of_pair(conv_chan, diff_pair);
   assign filt_step = state_r == ST_FILT;
   assign eval_step = state_r == ST_EVAL;
   assign host_cfg = cfg_wr && host_ok;
   assign host_data = data_wr && host_ok;
   assign host_clr = clr_chan && host_ok;
   assign alarm_hit = eval_step && cnt_nxt > {1'b0, fault_limit};
   assign clr_lsb = alarm_lsb(host_chan);
   assign set_lsb = alarm_lsb(ch_r);


   channel_average_filter u_filter (
      .acc(acc_r[ch_r]),
      .sample(sample_r),
      .avg_code(cfg_r[ch_r][`CLM_CFG_AVG_MSB:`CLM_CFG_AVG_LSB]),
      .is_signed(chan_signed[ch_r]),
      .acc_nxt(filt_nxt)
   );

   // The check reads the freshly updated data register.
   assign eval_data = acc_r[ch_r][23:12];
   assign eval_sgn = chan_signed[ch_r];
   assign above = greater(eval_data, upper_r[ch_r], eval_sgn);
   assign below = greater(lower_r[ch_r], eval_data, eval_sgn);
   assign eval_side = above ? `CLM_CODE_HIGH :
      (below ? `CLM_CODE_LOW : `CLM_CODE_NONE);
   assign fault_limit = cfg_r[ch_r][`CLM_CFG_FAULT_MSB:`CLM_CFG_FAULT_LSB];
   // Same-side faults extend the run; a new side restarts it at one.
   assign cnt_nxt = (eval_side == `CLM_CODE_NONE) ? 5'h00 :
      (eval_side != side_r[ch_r]) ? 5'h01 :
      count_up(cnt_r[ch_r]);

   // Conversion sequencing.
   always @* begin
      state_nxt = state_r;
      ch_nxt = ch_r;
      sample_nxt = sample_r;
      case (state_r)
         ST_IDLE: begin
            if (conv_take) begin
               ch_nxt = conv_chan;
               sample_nxt = conv_value;
               state_nxt = ST_FILT;
            end
         end
         ST_FILT: begin
            state_nxt = ST_EVAL;
         end
         ST_EVAL: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // State registers.
   always @(posedge clock) begin
      if (rst_all) begin
         state_r <= ST_IDLE;
         ch_r <= `CLM_CHAN_TEMP;
         sample_r <= 12'h000;
      end else begin
         state_r <= state_nxt;
         ch_r <= ch_nxt;
         sample_r <= sample_nxt;
      end
   end

   // Data registers; a host write seeds the filter and wins a collision.
   always @(posedge clock) begin
      if (rst_all) begin
         for (i = 0; i < `CLM_NUM_CHAN; i = i + 1) begin
            acc_r[i] <= {`CLM_DATA_RST, `CLM_FRAC_ZERO};
         end
      end else begin
         if (filt_step) begin
            acc_r[ch_r] <= filt_nxt;
         end
         if (host_data) begin
            acc_r[host_chan] <= {data_wr_value, `CLM_FRAC_ZERO};
         end
      end
   end

   // Limit and configuration registers.
   always @(posedge clock) begin
      if (rst_all) begin
         for (i = 0; i < `CLM_NUM_CHAN; i = i + 1) begin
            upper_r[i] <= `CLM_UPPER_RST;
            lower_r[i] <= `CLM_LOWER_RST;
            cfg_r[i] <= `CLM_CFG_RST;
         end
      end else if (cfg_wr && host_ok) begin
         upper_r[host_chan] <= cfg_wr_upper;
         lower_r[host_chan] <= cfg_wr_lower;
         cfg_r[host_chan] <= cfg_wr_byte;
      end
   end

   // Fault counters; a new configuration restarts the count.
   always @(posedge clock) begin
      if (rst_all) begin
         for (i = 0; i < `CLM_NUM_CHAN; i = i + 1) begin
            cnt_r[i] <= 5'h00;
            side_r[i] <= `CLM_CODE_NONE;
         end
      end else begin
         if (eval_step) begin
            cnt_r[ch_r] <= cnt_nxt;
            side_r[ch_r] <= eval_side;
         end
         if (cfg_wr && host_ok) begin
            cnt_r[host_chan] <= 5'h00;
            side_r[host_chan] <= `CLM_CODE_NONE;
         end
      end
   end

   // Alarm word: clears first, then a new alarm sets, so the set wins.
   always @* begin
      alarm_nxt = alarm_r;
      if (clr_all) begin
         alarm_nxt = `CLM_ALARM_RST;
      end else if (host_clr || host_cfg) begin
         alarm_nxt[clr_lsb +: 2] = `CLM_CODE_NONE;
      end
      if (alarm_hit) begin
         alarm_nxt[set_lsb +: 2] = eval_side;
      end
   end

   always @(posedge clock) begin
      if (rst_all) begin
         alarm_r <= `CLM_ALARM_RST;
      end else begin
         alarm_r <= alarm_nxt;
      end
   end

   // Interrupt pin: active while any alarm pair is nonzero.
   assign alarm_any = |alarm_r;
   assign level_active = alarm_any;
   assign int_out_nxt = int_active_high ? level_active
      : ~level_active;
   assign int_oe_nxt = int_drive_always | level_active;

   always @(posedge clock) begin
      if (rst_all) begin
         int_out <= 1'b1;
         int_oe <= 1'b0;
      end else begin
         int_out <= int_out_nxt;
         int_oe <= int_oe_nxt;
      end
   end

   // Read-back values of the selected channel; unknown channels read zero.
   always @* begin
      rd_result_nxt = 12'h000;
      rd_upper_nxt = 12'h000;
      rd_lower_nxt = 12'h000;
      rd_cfg_nxt = 8'h00;
      if (host_ok) begin
         rd_result_nxt = acc_r[host_chan][23:12];
         rd_upper_nxt = upper_r[host_chan];
         rd_lower_nxt = lower_r[host_chan];
         rd_cfg_nxt = cfg_r[host_chan];
      end
   end

   // Registered read-back of the selected channel and the alarm word.
   always @(posedge clock) begin
      if (rst_all) begin
         rd_result <= `CLM_DATA_RST;
         rd_upper <= `CLM_UPPER_RST;
         rd_lower <= `CLM_LOWER_RST;
         rd_cfg <= `CLM_CFG_RST;
         alarm_status <= `CLM_ALARM_RST;
      end else begin
         alarm_status <= alarm_r;
         rd_result <= rd_result_nxt;
         rd_upper <= rd_upper_nxt;
         rd_lower <= rd_lower_nxt;
         rd_cfg <= rd_cfg_nxt;
      end
   end
endmodule // channel_limit_monitor

//--- hdl/channel_limit_monitor_defines.vh
// Constants shared by the channel limit monitor design files.
`ifndef CHANNEL_LIMIT_MONITOR_DEFINES_VH
`define CHANNEL_LIMIT_MONITOR_DEFINES_VH
`define CLM_NUM_CHAN 4'ha
`define CLM_CHAN_TEMP 4'h0
`define CLM_CHAN_SUPPLY 4'h1
`define CLM_CHAN_AIN_FIRST 4'h2
`define CLM_CFG_FAULT_MSB 7
`define CLM_CFG_FAULT_LSB 4
`define CLM_CFG_AVG_MSB 3
`define CLM_CFG_AVG_LSB 0
`define CLM_CFG_RST 8'h00
`define CLM_UPPER_RST 12'hfff
`define CLM_LOWER_RST 12'h000
`define CLM_DATA_RST 12'h800
`define CLM_ALARM_RST 24'h000000
`define CLM_CODE_NONE 2'b00
`define CLM_CODE_LOW 2'b01
`define CLM_CODE_HIGH 2'b10
`define CLM_AVG_CODE_MAX 4'hb
`define CLM_FRAC_ZERO 12'h000
`define CLM_CNT_MAX 5'h10
`endif
